//--- inc/fbmc_regs.vh
// Purpose: constants for the full-bridge mode and fault control block
// Assumes: 25 MHz clock, Wishbone classic register slave
// Notes: register offsets are byte addresses of aligned 32-bit words
//
// What this block does
// - Alert output open-drain, low when operating normally
// - Alert released in standby or any fault
// - Switched supply off in standby or undervoltage
// - Standby when standby_n low or both directions low
// - Standby clears thermal and overcurrent shutdown
// - Motor supply undervoltage forces outputs off
// - Logic supply undervoltage forces outputs off
// - Over-temperature forces all outputs off
// - Thermal recovery needs cool and stop time elapsed
// - Grounded stop-time latches thermal shutdown
// - Four transistors monitored, two trip settings
// - Persistent overcurrent turns outputs off, alert high
// - Overcurrent recovers after stop time
// - Detection and stop times separately configurable
// - Grounded stop-time latches overcurrent shutdown
// - PWM alternates drive and short brake
// - Dead time inserted at every half-bridge switch
`ifndef FBMC_REGS_VH
`define FBMC_REGS_VH

`define FBMC_ADDR_CTRL 4'h0
`define FBMC_ADDR_TON 4'h4
`define FBMC_ADDR_TOFF 4'h8
`define FBMC_ADDR_STATUS 4'hc

`define FBMC_CTRL_LATCH_BIT 0
`define FBMC_CTRL_RESET 32'h0000_0000
`define FBMC_TON_RESET 16'h0019
`define FBMC_TOFF_RESET 16'h0100

`define FBMC_DEAD_NS 200
`define FBMC_CLK_MHZ 25
`define FBMC_DEAD_CYC ((`FBMC_DEAD_NS * `FBMC_CLK_MHZ + 999) / 1000)
`define FBMC_TICK_DIV 8'h19

`endif

//--- design/fbmc_top.v
// Purpose: mode decode, dead time and protection sequencing of a full-bridge driver
// Assumes: analog comparator results arrive as synchronous inputs
// Notes: stop and detection times count in 1 us ticks from a divider
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`include "fbmc_regs.vh"

module fbmc_top (
   input wire i_clk,
   input wire i_rst,
   input wire i_standby_n,
   input wire i_direction_in_a,
   input wire i_direction_in_b,
   input wire i_pwm,
   input wire i_motor_supply_low,
   input wire i_logic_supply_low,
   input wire i_over_temp,
   input wire i_temp_recovered,
   input wire [3:0] i_oc_detect,
   input wire [7:0] i_high_side_trip_set,
   input wire [7:0] i_low_side_trip_set,
   input wire [31:0] i_wb_adr,
   input wire [31:0] i_wb_dat,
   input wire [3:0] i_wb_sel,
   input wire i_wb_we,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   output reg o_high_a_on,
   output reg o_low_a_on,
   output reg o_high_b_on,
   output reg o_low_b_on,
   output reg [7:0] o_high_side_trip_set,
   output reg [7:0] o_low_side_trip_set,
   output reg o_alert_o,
   output reg o_alert_oe,
   output reg o_switched_supply_out_o,
   output reg o_switched_supply_out_oe
);

   // ****************************************************************
   // Register file
   // ****************************************************************
   reg latch_mode;
   reg [15:0] ton_ticks;
   reg [15:0] toff_ticks;
   wire wb_req;
   wire [31:0] status_word;
   wire [3:0] wb_off;
   reg thermal_shutdown;
   reg overcurrent_shutdown;
   wire undervoltage_lockout;
   wire standby;

   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wb_off = i_wb_adr[3:0];
   assign status_word = {26'h0, standby, undervoltage_lockout,
                         overcurrent_shutdown, thermal_shutdown, i_oc_detect[1:0] != 2'h0,
                         i_oc_detect[3:2] != 2'h0};

   // Zero stop time models the grounded stop-time pin
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         latch_mode <= 1'b0;
         ton_ticks <= `FBMC_TON_RESET;
         toff_ticks <= `FBMC_TOFF_RESET;
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0;
      end else begin
         o_wb_ack <= wb_req;
         if (wb_req & i_wb_we) begin
            case (wb_off)
               `FBMC_ADDR_CTRL: begin
                  if (i_wb_sel[0])
                     latch_mode <= i_wb_dat[`FBMC_CTRL_LATCH_BIT];
               end
               `FBMC_ADDR_TON: begin
                  if (i_wb_sel[0])
                     ton_ticks[7:0] <= i_wb_dat[7:0];
                  if (i_wb_sel[1])
                     ton_ticks[15:8] <= i_wb_dat[15:8];
               end
               `FBMC_ADDR_TOFF: begin
                  if (i_wb_sel[0])
                     toff_ticks[7:0] <= i_wb_dat[7:0];
                  if (i_wb_sel[1])
                     toff_ticks[15:8] <= i_wb_dat[15:8];
               end
               default: begin
               end
            endcase
         end
         if (wb_req & ~i_wb_we) begin
            case (wb_off)
               `FBMC_ADDR_CTRL: o_wb_dat <= {31'h0, latch_mode};
               `FBMC_ADDR_TON: o_wb_dat <= {16'h0, ton_ticks};
               `FBMC_ADDR_TOFF: o_wb_dat <= {16'h0, toff_ticks};
               `FBMC_ADDR_STATUS: o_wb_dat <= status_word;
               default: o_wb_dat <= 32'h0;
            endcase
         end
      end
   end

   // ****************************************************************
   // Microsecond tick
   // ****************************************************************
   reg [7:0] div_cnt;
   reg tick;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_cnt <= 8'h0;
         tick <= 1'b0;
      end else if (div_cnt == `FBMC_TICK_DIV - 8'h1) begin
         div_cnt <= 8'h0;
         tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 8'h1;
         tick <= 1'b0;
      end
   end

   // ****************************************************************
   // Protection
   // ****************************************************************
   wire oc_any;
   wire no_auto;
   reg [15:0] ton_cnt;
   reg [15:0] toff_cnt;
   wire toff_done;

   assign oc_any = |i_oc_detect;
   assign undervoltage_lockout = i_motor_supply_low | i_logic_supply_low;
   assign standby = ~i_standby_n | (~i_direction_in_a & ~i_direction_in_b);
   assign no_auto = latch_mode | (toff_ticks == 16'h0);
   assign toff_done = (toff_cnt >= toff_ticks);

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         thermal_shutdown <= 1'b0;
         overcurrent_shutdown <= 1'b0;
         ton_cnt <= 16'h0;
         toff_cnt <= 16'h0;
      end else if (standby) begin
         thermal_shutdown <= 1'b0;
         overcurrent_shutdown <= 1'b0;
         ton_cnt <= 16'h0;
         toff_cnt <= 16'h0;
      end else begin
         if (oc_any & ~overcurrent_shutdown) begin
            if (tick)
               ton_cnt <= ton_cnt + 16'h1;
         end else begin
            ton_cnt <= 16'h0;
         end
         if (thermal_shutdown | overcurrent_shutdown) begin
            if (tick & ~toff_done)
               toff_cnt <= toff_cnt + 16'h1;
         end else begin
            toff_cnt <= 16'h0;
         end
         // Detection has priority over recovery in the same cycle
         if (i_over_temp) begin
            thermal_shutdown <= 1'b1;
         end else if (thermal_shutdown & i_temp_recovered & toff_done & ~no_auto) begin
            thermal_shutdown <= 1'b0;
         end
         if (oc_any & ~overcurrent_shutdown & (ton_cnt >= ton_ticks)) begin
            overcurrent_shutdown <= 1'b1;
         end else if (overcurrent_shutdown & toff_done & ~no_auto) begin
            overcurrent_shutdown <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Mode decode and dead time
   // ****************************************************************
   wire bridge_off;
   reg next_high_a;
   reg next_low_a;
   reg next_high_b;
   reg next_low_b;
   reg [7:0] dead_cnt;
   reg [3:0] cur_req;

   assign bridge_off = standby | undervoltage_lockout | thermal_shutdown | overcurrent_shutdown;

   // Order is high_a, low_a, high_b, low_b
   always @* begin
      next_high_a = 1'b0;
      next_low_a = 1'b0;
      next_high_b = 1'b0;
      next_low_b = 1'b0;
      if (!bridge_off) begin
         if (i_pwm | (i_direction_in_a & i_direction_in_b)) begin
            next_low_a = 1'b1;
            next_low_b = 1'b1;
         end else if (i_direction_in_a) begin
            next_high_a = 1'b1;
            next_low_b = 1'b1;
         end else begin
            next_low_a = 1'b1;
            next_high_b = 1'b1;
         end
      end
   end

   // A changing request first turns every switch off, then waits out the dead time.
   // Turn-off is immediate so a fault never waits on the timer.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cur_req <= 4'h0;
         dead_cnt <= 8'h0;
         o_high_a_on <= 1'b0;
         o_low_a_on <= 1'b0;
         o_high_b_on <= 1'b0;
         o_low_b_on <= 1'b0;
      end else if ({next_high_a, next_low_a, next_high_b, next_low_b} != cur_req) begin
         cur_req <= {next_high_a, next_low_a, next_high_b, next_low_b};
         dead_cnt <= 8'h0;
         o_high_a_on <= 1'b0;
         o_low_a_on <= 1'b0;
         o_high_b_on <= 1'b0;
         o_low_b_on <= 1'b0;
      end else if (dead_cnt < `FBMC_DEAD_CYC) begin
         dead_cnt <= dead_cnt + 8'h1;
      end else begin
         {o_high_a_on, o_low_a_on, o_high_b_on, o_low_b_on} <= cur_req;
      end
   end

   // ****************************************************************
   // Status pins
   // ****************************************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_alert_o <= 1'b0;
         o_alert_oe <= 1'b0;
         o_switched_supply_out_o <= 1'b0;
         o_switched_supply_out_oe <= 1'b0;
         o_high_side_trip_set <= 8'h0;
         o_low_side_trip_set <= 8'h0;
      end else begin
         o_alert_o <= 1'b0;
         o_alert_oe <= ~bridge_off;
         o_switched_supply_out_o <= 1'b0;
         o_switched_supply_out_oe <= ~(standby | undervoltage_lockout);
         o_high_side_trip_set <= i_high_side_trip_set;
         o_low_side_trip_set <= i_low_side_trip_set;
      end
   end

endmodule

//--- testbench/fbmc_host.sv
// Purpose: host pin driver. Assumes: mode is {standby_n, dir_a, dir_b, pwm}. Notes: no off gap
`timescale 1ns/10ps
module fbmc_host (
   input wire i_clk,
   input wire [3:0] i_mode,
   output reg o_standby_n = 1'h0,
   output reg o_dir_a = 1'h0,
   output reg o_dir_b = 1'h0,
   output reg o_pwm = 1'h0
);
   always @(posedge i_clk) begin
      {o_standby_n, o_dir_a, o_dir_b, o_pwm} <= i_mode;
   end
endmodule

//--- testbench/fbmc_chk.sv
// Purpose: bridge and status checks. Assumes: one clock. Notes: supply faults act in one cycle, over-temperature in two
`timescale 1ns/10ps
module fbmc_chk (
   input wire i_clk,
   input wire i_rst,
   input wire i_standby_n,
   input wire i_direction_in_a,
   input wire i_direction_in_b,
   input wire i_motor_supply_low,
   input wire i_logic_supply_low,
   input wire i_over_temp,
   input wire o_high_a_on,
   input wire o_low_a_on,
   input wire o_high_b_on,
   input wire o_low_b_on,
   input wire o_alert_o,
   input wire o_alert_oe,
   input wire o_switched_supply_out_oe
);
   wire off = !(o_high_a_on || o_low_a_on || o_high_b_on || o_low_b_on);
   wire standby_n = !i_standby_n || !(i_direction_in_a || i_direction_in_b);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_gap_a; (!o_high_a_on)[*4]; endsequence
   sequence s_gap_b; (!o_low_b_on)[*4]; endsequence
   property p_dead_a; $fell(o_low_a_on) |=> s_gap_a; endproperty
   a_dead_a: assert property (p_dead_a) else $error("gap a short");
   property p_dead_b; $fell(o_high_b_on) |=> s_gap_b; endproperty
   a_dead_b: assert property (p_dead_b) else $error("gap b short");
   property p_shoot; !(o_high_a_on && o_low_a_on || o_high_b_on && o_low_b_on); endproperty
   a_shoot: assert property (p_shoot) else $error("shoot through");
   property p_standby_n; standby_n |=> off; endproperty
   a_standby_n: assert property (p_standby_n) else $error("standby drive");
   property p_rel; standby_n |=> !o_alert_oe && !o_switched_supply_out_oe; endproperty
   a_rel: assert property (p_rel) else $error("standby status");
   property p_uv; i_motor_supply_low || i_logic_supply_low |=> off && !o_alert_oe; endproperty
   a_uv: assert property (p_uv) else $error("low supply drive");
   property p_hot; i_over_temp |-> ##2 off && !o_alert_oe; endproperty
   a_hot: assert property (p_hot) else $error("hot drive");
   property p_od; o_alert_oe |-> !o_alert_o && !$past(standby_n); endproperty
   a_od: assert property (p_od) else $error("alert state");
endmodule
bind fbmc_top fbmc_chk fbmc_chk_i (.*);

//--- testbench/full_bridge_mode_and_fault_control_test.sv
// Purpose: bridge control bench. Assumes: 1 us ticks. Notes: br is {ha, la, hb, lb}
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("Error %s exp %h got %h", n, e, g); end end
module full_bridge_mode_and_fault_control_test;
   reg clk = 1'h0, rst = 1'h1, mlow = 1'h0, llow = 1'h0, hot = 1'h0, cool = 1'h0;
   reg cyc = 1'h0, stb = 1'h0, we = 1'h0;
   reg [3:0] mode = 4'h0, oc = 4'h0;
   reg [7:0] hs = 8'h00, ls = 8'h00;
   reg [31:0] adr = 32'h0, wd = 32'h0, q, seed = 32'h91e2a1d8;
   wire sb, da, db, pwm, ack, aoe, soe, ao, so;
   wire [7:0] hso, lso;
   wire [3:0] br;
   wire [31:0] rd;
   integer errors = 0, n_checks = 0, k;
   // Faults in turn: motor low, logic low, hot, oc, hot, oc
   wire [41:0] flt = {7'h08, 7'h10, 7'h02, 7'h10, 7'h20, 7'h40};
   always #20 clk = ~clk;
   fbmc_host fbmc_host_i (.i_clk(clk), .i_mode(mode), .o_standby_n(sb), .o_dir_a(da),
      .o_dir_b(db), .o_pwm(pwm));
   fbmc_top fbmc_top_i (.i_clk(clk), .i_rst(rst), .i_standby_n(sb), .i_direction_in_a(da),
      .i_direction_in_b(db), .i_pwm(pwm), .i_motor_supply_low(mlow), .i_over_temp(hot),
      .i_logic_supply_low(llow), .i_temp_recovered(cool), .i_oc_detect(oc), .i_wb_adr(adr),
      .i_high_side_trip_set(hs), .i_low_side_trip_set(ls), .i_wb_dat(wd), .i_wb_sel(4'hf),
      .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rd), .o_wb_ack(ack),
      .o_high_a_on(br[3]), .o_low_a_on(br[2]), .o_high_b_on(br[1]), .o_low_b_on(br[0]),
      .o_high_side_trip_set(hso), .o_low_side_trip_set(lso), .o_alert_o(ao),
      .o_alert_oe(aoe), .o_switched_supply_out_o(so), .o_switched_supply_out_oe(soe));
   function [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function [3:0] model(input [3:0] m);
      return !m[3] || m[2:1] == 2'h0 ? 4'h0 : m[0] || m[2] == m[1] ? 4'h5 : m[2] ? 4'h9 : 4'h6;
   endfunction
   task pause(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // Request held until ack is seen; a stuck slave is left to the watchdog
   task wb(input [31:0] a, input w, input [31:0] d);
      @(posedge clk);
      {adr, we, wd, cyc, stb} <= {a, w, d, 2'h3};
      @(posedge clk);
      while (ack !== 1'h1) @(posedge clk);
      q = rd;
      {cyc, stb} <= 2'h0;
   endtask
   task st(input [3:0] e, input [1:0] s);
      `CHK("bridge", e, br)
      `CHK("alert supply", {s, 2'h0}, {aoe, soe, ao, so})
   endtask
   task end_sim;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #400000 errors++;
      end_sim;
   end
   initial begin
      pause(10);
      rst <= 1'h0;
      wb(32'h8, 1'h0, 32'h0);
      `CHK("toff", 32'h100, q)
      wb(32'h2, 1'h0, 32'h0);
      `CHK("unmapped", 32'h0, q)
      wb(32'h4, 1'h1, 32'h2);
      wb(32'h8, 1'h1, 32'h3);
      for (k = 0; k < 16; k++) begin
         {mode, hs, ls} <= {k[3:0], rnd(), rnd()};
         pause(12);
         st(model(k[3:0]), {2{k[3] && k[2:1] != 2'h0}});
         `CHK("trip", {hs, ls}, {hso, lso})
      end
      for (k = 0; k < 6; k++) begin
         if (k == 4) wb(32'h8, 1'h1, 32'h0);
         cool <= k != 2;
         {mode, mlow, llow, hot, oc} <= {4'hc, flt[k * 7 +: 7]};
         pause(100);
         st(4'h0, {1'h0, k > 1});
         {mlow, llow, hot, oc} <= 7'h00;
         pause(200);
         st(k == 2 || k > 3 ? 4'h0 : 4'h9, {k < 2 || k == 3, 1'h1});
         mode <= 4'h4;
         pause(5);
         mode <= 4'hc;
         pause(20);
         st(4'h9, 2'h3);
      end
      end_sim;
   end
endmodule
